/* bmsd_pkg.sv */
// Package for the bridge mode, strap and decode control block.
// Assumes a single 10 MHz clock domain; the main and memory files import it whole.
package bmsd_pkg;

  // ****************************************************************
  // Configuration space layout (byte offsets)
  // ****************************************************************
  localparam logic [11:0] OFS_ID        = 12'h000;
  localparam logic [11:0] OFS_CLASS     = 12'h008;
  localparam logic [11:0] OFS_HDR       = 12'h00c;
  localparam logic [11:0] OFS_BUSNUM    = 12'h018;
  localparam logic [11:0] OFS_IOWIN     = 12'h01c;
  localparam logic [11:0] OFS_MEMWIN    = 12'h020;
  localparam logic [11:0] OFS_CAPPTR    = 12'h034;
  localparam logic [11:0] OFS_PMCAP     = 12'h080;
  localparam logic [11:0] OFS_PCIECAP   = 12'h0b0;
  localparam logic [11:0] OFS_PCIECAP_E = 12'h0bc;
  localparam logic [11:0] OFS_LEGACY    = 12'h098;
  localparam logic [11:0] OFS_EXT       = 12'h100;

  // ****************************************************************
  // Field positions and fixed values
  // ****************************************************************
  localparam int          LEGACY_BIT    = 0;
  localparam int          SUBDEC_BIT    = 1;
  localparam logic [7:0]  BASE_CLASS    = 8'h06;
  localparam logic [7:0]  SUB_CLASS     = 8'h04;
  localparam logic [7:0]  PROGIF_POS    = 8'h00;
  localparam logic [7:0]  PROGIF_SUB    = 8'h01;
  localparam logic [7:0]  HDR_TYPE1     = 8'h01;
  localparam logic [7:0]  CAP_ID_PM     = 8'h01;
  localparam logic [7:0]  CAP_ID_PCIE   = 8'h10;
  localparam logic [3:0]  PCIE_CAP_VER  = 4'h1;
  localparam logic [1:0]  CPM_STRAP_VAL = 2'h0;
  localparam logic [15:0] VENDOR_ID     = 16'h1234; // Arbitrary value
  localparam logic [15:0] DEVICE_ID     = 16'h5678; // Arbitrary value
  localparam logic [7:0]  REVISION_ID   = 8'h01;    // Arbitrary value
  localparam logic [1:0]  LEGACY_RST    = 2'h0;
  localparam int          MEM_AW        = 6;

endpackage

/* bmsd_cfg_mem.sv */
// Configuration dword store: 64 words, one write port, registered read.
// Assumes reads and writes come from the main control on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bmsd_cfg_mem
  import bmsd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              wen,
  input  wire logic [MEM_AW-1:0] addr,
  input  wire logic [31:0]       wdata,
  output logic      [31:0]       rdata
);

  logic [31:0] mem_q [2**MEM_AW];
  logic [31:0] rdata_q;

  // ****************************************************************
  // Storage and registered read
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (wen)
    begin
      mem_q[addr] <= wdata;
    end
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      rdata_q <= mem_q[addr];
    end
  end

  assign rdata = rdata_q;

endmodule
`default_nettype wire

/* bmsd_ctrl.sv */
// Bridge mode, strap sampling, class code, configuration access and decode control.
// Assumes strap and reset pins are asynchronous; configuration and decode
// requests come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Sample request lines 3:2 at reset release if normal mode strap low
// - Zero straps enable clock PM, two devices
// - Clock outputs 2,3 become request, run
// - Report class 06h, sub-class 04h
// - Prog interface 00h, or 01h when legacy
// - Legacy bit forwards all memory, IO downstream
// - Type-1 config forwarded only within bus range
// - Legacy hides PCIe capability; extended space always hidden
// - Reserved space: writes dropped, reads zero
// - Cycles outside windows claimed; subtractive bit flags them
// - Type-1 header behaves like transparent bridge
// - Serve configuration requests from PCIe side
// - I2C access only with EEPROM strap low
// - PCIe upstream, PCI downstream
module bmsd_ctrl
  import bmsd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        eeprom_mode_strap,
  input  wire logic        normal_mode_strap,
  input  wire logic        fundamental_reset_n,
  input  wire logic [3:0]  pci_req_n,
  input  wire logic [3:0]  clk_src,
  input  wire logic        clock_request_int_n,
  input  wire logic        clock_run_pin,
  input  wire logic        clock_run_assert,
  output logic [3:0]       pci_clock_out,
  output logic             clock_run_n_out,
  output logic             clock_run_n_oe_n,
  output logic             clock_run_n_seen,
  output logic             clk_pm_en,
  output logic             two_device_mode,
  input  wire logic        cfg_req,
  input  wire logic        cfg_from_i2c,
  input  wire logic        cfg_write,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  input  wire logic        dn_valid,
  input  wire logic        dn_is_io,
  input  wire logic        dn_is_cfg1,
  input  wire logic [7:0]  dn_bus,
  input  wire logic [31:0] dn_addr,
  output logic             dn_forward,
  input  wire logic        up_valid,
  input  wire logic        up_is_io,
  input  wire logic [31:0] up_addr,
  output logic             up_claim,
  output logic             up_claim_subtractive,
  output logic             legacy_en,
  output logic             subdec_en
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [5:0] sync1_q, sync2_q, sync1_d, sync2_d;
  logic       perst_prev_q, perst_prev_d;
  logic       cpm_q, cpm_d;
  logic       crun_q, crun_d;

  // Two stages for reset, both mode straps, request straps and clock-run pin
  always_comb
  begin
    sync1_d      = {clock_run_pin, eeprom_mode_strap, normal_mode_strap,
                    fundamental_reset_n, pci_req_n[3:2]};
    sync2_d      = sync1_q;
    perst_prev_d = sync2_q[2];
    // Cleared while reset is low, latched on its synchronised rising edge if normal mode strap is low
    cpm_d        = cpm_q && sync2_q[2];
    if (sync2_q[2] && !perst_prev_q && !sync2_q[3])
    begin
      cpm_d = (sync2_q[1:0] == CPM_STRAP_VAL);
    end
    crun_d = sync2_q[5];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_q      <= 6'h20; // Clock-run wire idles high
      sync2_q      <= 6'h20;
      perst_prev_q <= 1'b0;
      cpm_q        <= 1'b0;
      crun_q       <= 1'b1;
    end
    else
    begin
      sync1_q      <= sync1_d;
      sync2_q      <= sync2_d;
      perst_prev_q <= perst_prev_d;
      cpm_q        <= cpm_d;
      crun_q       <= crun_d;
    end
  end

  assign clk_pm_en        = cpm_q;
  assign two_device_mode  = cpm_q;
  assign clock_run_n_seen = crun_q;

  // ****************************************************************
  // Clock output mux
  // ****************************************************************
  logic [3:0] pci_clock_out_q, pci_clock_out_d;
  logic       crun_oe_n_q, crun_oe_n_d;

  // Outputs 2 and 3 take over request and run roles under clock PM
  always_comb
  begin
    pci_clock_out_d    = clk_src;
    crun_oe_n_d = 1'b1;
    if (cpm_q)
    begin
      pci_clock_out_d[2] = clock_request_int_n;
      pci_clock_out_d[3] = crun_q;
      crun_oe_n_d = !clock_run_assert;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pci_clock_out_q    <= 4'h0;
      crun_oe_n_q <= 1'b1;
    end
    else
    begin
      pci_clock_out_q    <= pci_clock_out_d;
      crun_oe_n_q <= crun_oe_n_d;
    end
  end

  assign pci_clock_out    = pci_clock_out_q;
  assign clock_run_n_out  = 1'b0; // Open drain, only ever pulls low
  assign clock_run_n_oe_n = crun_oe_n_q;

  // ****************************************************************
  // Configuration access
  // ****************************************************************
  logic [1:0]  ctl_q, ctl_d;
  logic [31:0] bus_q, bus_d, iow_q, iow_d, memw_q, memw_d;
  logic        p1_q, p1_d, ack_q, ack_d;
  logic [11:0] p1_addr_q, p1_addr_d;
  logic        p1_zero_q, p1_zero_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] mem_rdata;
  logic        mem_wen, in_pcie_cap, reserved, refused;
  logic [7:0]  progif;

  assign in_pcie_cap = (cfg_addr >= OFS_PCIECAP) && (cfg_addr <= OFS_PCIECAP_E);
  assign reserved    = (cfg_addr >= OFS_EXT) || (ctl_q[LEGACY_BIT] && in_pcie_cap);
  assign refused     = cfg_from_i2c && sync2_q[4];
  assign progif      = ctl_q[LEGACY_BIT] ? PROGIF_SUB : PROGIF_POS;

  // Store writes, shadow decode registers, build read data
  always_comb
  begin
    ctl_d     = ctl_q;
    bus_d     = bus_q;
    iow_d     = iow_q;
    memw_d    = memw_q;
    mem_wen   = 1'b0;
    p1_d      = cfg_req;
    p1_addr_d = {cfg_addr[11:2], 2'b00};
    p1_zero_d = reserved || refused;
    ack_d     = p1_q;
    rdata_d   = 32'h0000_0000;
    if (cfg_req && cfg_write && !reserved && !refused)
    begin
      mem_wen = 1'b1;
      case ({cfg_addr[11:2], 2'b00})
        OFS_LEGACY: ctl_d  = cfg_wdata[1:0];
        OFS_BUSNUM: bus_d  = cfg_wdata;
        OFS_IOWIN:  iow_d  = cfg_wdata;
        OFS_MEMWIN: memw_d = cfg_wdata;
        default:    ctl_d  = ctl_q;
      endcase
    end
    if (p1_q && !p1_zero_q)
    begin
      case (p1_addr_q)
        OFS_ID:      rdata_d = {DEVICE_ID, VENDOR_ID};
        OFS_CLASS:   rdata_d = {BASE_CLASS, SUB_CLASS, progif, REVISION_ID};
        OFS_HDR:     rdata_d = {mem_rdata[31:24], HDR_TYPE1, mem_rdata[15:0]};
        OFS_CAPPTR:  rdata_d = {24'h000000, OFS_PMCAP[7:0]};
        // Legacy mode ends the chain at power management
        OFS_PMCAP:   rdata_d = {16'h0000, (ctl_q[LEGACY_BIT] ? 8'h00 : OFS_PCIECAP[7:0]),
                                CAP_ID_PM};
        OFS_PCIECAP: rdata_d = {12'h000, PCIE_CAP_VER, 8'h00, CAP_ID_PCIE};
        OFS_LEGACY:  rdata_d = {30'h0, ctl_q};
        default:     rdata_d = mem_rdata;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctl_q     <= LEGACY_RST;
      bus_q     <= 32'h0000_0000;
      iow_q     <= 32'h0000_0000;
      memw_q    <= 32'h0000_0000;
      p1_q      <= 1'b0;
      p1_addr_q <= 12'h000;
      p1_zero_q <= 1'b0;
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ctl_q     <= ctl_d;
      bus_q     <= bus_d;
      iow_q     <= iow_d;
      memw_q    <= memw_d;
      p1_q      <= p1_d;
      p1_addr_q <= p1_addr_d;
      p1_zero_q <= p1_zero_d;
      ack_q     <= ack_d;
      rdata_q   <= rdata_d;
    end
  end

  bmsd_cfg_mem u_mem (
    .mclk  (mclk),
    .rst   (rst),
    .wen   (mem_wen),
    .addr  (cfg_addr[MEM_AW+1:2]),
    .wdata (cfg_wdata),
    .rdata (mem_rdata)
  );

  assign cfg_ack   = ack_q;
  assign cfg_rdata = rdata_q;
  assign legacy_en = ctl_q[LEGACY_BIT];
  assign subdec_en = ctl_q[SUBDEC_BIT];

  // ****************************************************************
  // Address decode, PCIe upstream and PCI downstream
  // ****************************************************************
  logic dn_in_win, up_in_win, bus_ok;
  logic fwd_q, fwd_d, claim_q, claim_d, csub_q, csub_d;

  // IO window in 4 KB units, memory window in 1 MB units
  assign dn_in_win = dn_is_io ?
    ((dn_addr[15:12] >= iow_q[7:4]) && (dn_addr[15:12] <= iow_q[15:12])) :
    ((dn_addr[31:20] >= memw_q[15:4]) && (dn_addr[31:20] <= memw_q[31:20]));
  assign up_in_win = up_is_io ?
    ((up_addr[15:12] >= iow_q[7:4]) && (up_addr[15:12] <= iow_q[15:12])) :
    ((up_addr[31:20] >= memw_q[15:4]) && (up_addr[31:20] <= memw_q[31:20]));
  assign bus_ok = (dn_bus >= bus_q[15:8]) && (dn_bus <= bus_q[23:16]);

  // Forward downstream from the upstream port, claim upstream on PCI
  always_comb
  begin
    fwd_d   = dn_valid && (dn_is_cfg1 ? bus_ok : (ctl_q[LEGACY_BIT] || dn_in_win));
    claim_d = up_valid && !up_in_win;
    csub_d  = claim_d && ctl_q[SUBDEC_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fwd_q   <= 1'b0;
      claim_q <= 1'b0;
      csub_q  <= 1'b0;
    end
    else
    begin
      fwd_q   <= fwd_d;
      claim_q <= claim_d;
      csub_q  <= csub_d;
    end
  end

  assign dn_forward           = fwd_q;
  assign up_claim             = claim_q;
  assign up_claim_subtractive = csub_q;

endmodule
`default_nettype wire

/* bmsd_monitor.sv */
// Concurrent checks on the ports of the strap and decode control block.
// Assumes one clock domain and a bind onto every bmsd_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module bmsd_monitor
  import bmsd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cfg_req,
  input wire logic        cfg_write,
  input wire logic [11:0] cfg_addr,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        dn_valid,
  input wire logic        dn_is_cfg1,
  input wire logic        dn_forward,
  input wire logic        up_claim,
  input wire logic        up_claim_subtractive,
  input wire logic        legacy_en,
  input wire logic        subdec_en,
  input wire logic        clk_pm_en,
  input wire logic        two_device_mode,
  input wire logic        clock_run_n_oe_n,
  input wire logic        clock_run_n_out,
  input wire logic        clock_request_int_n,
  input wire logic [3:0]  pci_clock_out,
  input wire logic [3:0]  pci_req_n,
  input wire logic        fundamental_reset_n
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ack_time; cfg_req |-> ##2 cfg_ack; endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack late");
  property p_ack_cause; cfg_ack |-> $past(cfg_req, 2); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_idle; !cfg_ack |-> cfg_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_ext; cfg_req && !cfg_write && cfg_addr >= OFS_EXT |-> ##2 cfg_rdata == 32'h0;
  endproperty
  a_ext: assert property (p_ext) else $error("extended read not zero");
  property p_hide;
    cfg_req && !cfg_write && cfg_addr[11:4] == 8'h0b && legacy_en ##1 legacy_en[*2]
      |-> cfg_rdata == 32'h0;
  endproperty
  a_hide: assert property (p_hide) else $error("hidden capability visible");
  property p_fwd; dn_valid && !dn_is_cfg1 && legacy_en |=> dn_forward; endproperty
  a_fwd: assert property (p_fwd) else $error("cycle not forwarded");
  property p_sub; up_claim_subtractive |-> up_claim && $past(subdec_en); endproperty
  a_sub: assert property (p_sub) else $error("bad subtractive claim");
  property p_run; !clock_run_n_oe_n |-> $past(clk_pm_en) && clock_run_n_out == 1'b0;
  endproperty
  a_run: assert property (p_run) else $error("clock run driven wrongly");
  property p_creq;
    clk_pm_en && $past(clk_pm_en) |-> pci_clock_out[2] == $past(clock_request_int_n);
  endproperty
  a_creq: assert property (p_creq) else $error("clock request not routed");
  property p_two;
    two_device_mode == clk_pm_en
      && (!$rose(clk_pm_en) || $past(pci_req_n[3:2], 3) == CPM_STRAP_VAL);
  endproperty
  a_two: assert property (p_two) else $error("device mode differs");
  property p_hold; clk_pm_en && fundamental_reset_n && $past(fundamental_reset_n) |=> clk_pm_en;
  endproperty
  a_hold: assert property (p_hold) else $error("latched strap lost");
endmodule
bind bmsd_ctrl bmsd_monitor u_mon (.mclk, .rst, .cfg_req, .cfg_write, .cfg_addr, .cfg_ack,
  .cfg_rdata, .dn_valid, .dn_is_cfg1, .dn_forward, .up_claim, .up_claim_subtractive,
  .legacy_en, .subdec_en, .clk_pm_en, .two_device_mode, .clock_run_n_oe_n,
  .clock_run_n_out, .clock_request_int_n, .pci_clock_out, .pci_req_n, .fundamental_reset_n);
`default_nettype wire

/* bmsd_board.sv */
// Board model: mode straps, reset pin, request straps and clock-run wire.
// Assumes the bench steers reset and strap choice at clock edges.
`timescale 1ns/1ps
`default_nettype none
module bmsd_board (
  input  wire logic       perst_hold,
  input  wire logic [1:0] strap_sel,
  input  wire logic       clock_run_n_oe_n,
  input  wire logic       clock_run_n_out,
  output logic            eeprom_mode_strap,
  output logic            normal_mode_strap,
  output logic            fundamental_reset_n,
  output logic [3:0]      pci_req_n,
  output logic            clock_run_pin
);
  // ****************************************************************
  // Strap pins and pulled-up clock-run wire
  // ****************************************************************
  assign eeprom_mode_strap = 1'b0;
  assign normal_mode_strap = 1'b0;
  assign fundamental_reset_n = ~perst_hold;
  assign pci_req_n = {strap_sel, 2'b11};
  assign clock_run_pin = clock_run_n_oe_n ? 1'b1 : clock_run_n_out;
endmodule
`default_nettype wire

/* bmsd_ctrl_bench.sv */
// Self-checking bench for the strap and decode control block.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module bmsd_ctrl_bench
  import bmsd_pkg::*;
;
  // ****************************************************************
  // Stimulus signals, design and board
  // ****************************************************************
  logic mclk = 0, rst = 1, perst_hold = 1, clock_request_int_n = 1, clock_run_assert = 0;
  logic cfg_req = 0, cfg_from_i2c = 0, cfg_write = 0, dn_valid = 0, dn_is_io = 0;
  logic dn_is_cfg1 = 0, up_valid = 0, up_is_io = 0;
  logic [1:0] strap_sel = 0;
  logic [3:0] clk_src = 0, pci_req_n, pci_clock_out;
  logic [7:0] dn_bus = 0;
  logic [11:0] cfg_addr = 0;
  logic [31:0] cfg_wdata = 0, dn_addr = 0, up_addr = 0, cfg_rdata;
  logic eeprom_mode_strap, normal_mode_strap, fundamental_reset_n, clock_run_pin;
  logic clock_run_n_out, clock_run_n_oe_n, clock_run_n_seen, clk_pm_en, two_device_mode;
  logic cfg_ack, dn_forward, up_claim, up_claim_subtractive, legacy_en, subdec_en;
  int n_mismatch = 0, checked = 0;
  bmsd_board u_board (.perst_hold, .strap_sel, .clock_run_n_oe_n, .clock_run_n_out,
    .eeprom_mode_strap, .normal_mode_strap, .fundamental_reset_n, .pci_req_n, .clock_run_pin);
  bmsd_ctrl DUT (.mclk, .rst, .eeprom_mode_strap, .normal_mode_strap, .fundamental_reset_n,
    .pci_req_n, .clk_src, .clock_request_int_n, .clock_run_pin, .clock_run_assert,
    .pci_clock_out, .clock_run_n_out, .clock_run_n_oe_n, .clock_run_n_seen, .clk_pm_en,
    .two_device_mode, .cfg_req, .cfg_from_i2c, .cfg_write, .cfg_addr, .cfg_wdata, .cfg_ack,
    .cfg_rdata, .dn_valid, .dn_is_io, .dn_is_cfg1, .dn_bus, .dn_addr, .dn_forward,
    .up_valid, .up_is_io, .up_addr, .up_claim, .up_claim_subtractive, .legacy_en, .subdec_en);
  // Clock and watchdog
  always #50 mclk = ~mclk;
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One configuration dword access; reads compare against e
  task automatic cfg(input logic i2c, wr, input logic [11:0] a, input logic [31:0] d, e);
    int n;
    @(posedge mclk);
    cfg_req <= 1'b1;
    cfg_from_i2c <= i2c;
    cfg_write <= wr;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (cfg_ack !== 1'b1 && n < 4);
    cmp({31'h0, cfg_ack}, 32'h1);
    if (!wr)
      cmp(cfg_rdata, e);
  endtask
  // One downstream cycle; e is the expected forward decision
  task automatic dn(input logic io, c1, input logic [7:0] b, input logic e);
    @(posedge mclk);
    dn_valid <= 1'b1;
    dn_is_io <= io;
    dn_is_cfg1 <= c1;
    dn_bus <= b;
    dn_addr <= 32'h00500000;
    @(posedge mclk);
    dn_valid <= 1'b0;
    #1;
    cmp({31'h0, dn_forward}, {31'h0, e});
  endtask
  // One secondary-bus cycle; ec and es are the expected claims
  task automatic up(input logic io, input logic [31:0] a, input logic ec, es);
    @(posedge mclk);
    up_valid <= 1'b1;
    up_is_io <= io;
    up_addr <= a;
    @(posedge mclk);
    up_valid <= 1'b0;
    #1;
    cmp({30'h0, up_claim, up_claim_subtractive}, {30'h0, ec, es});
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (4) @(posedge mclk);
    #1;
    cmp({29'h0, clk_pm_en, clock_run_n_oe_n, legacy_en}, 32'h2);
    @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    perst_hold <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    cmp({30'h0, clk_pm_en, two_device_mode}, 32'h3);
    @(posedge mclk);
    strap_sel <= 2'b11;
    clk_src <= 4'hf;
    clock_request_int_n <= 1'b0;
    clock_run_assert <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    cmp({30'h0, clk_pm_en, two_device_mode}, 32'h3);
    cmp({28'h0, pci_clock_out[3:2], clock_run_n_oe_n, clock_run_n_seen}, 32'h0);
    cmp({30'h0, pci_clock_out[1:0]}, 32'h3);
    @(posedge mclk);
    clock_run_assert <= 1'b0;
    perst_hold <= 1'b1;
    repeat (6) @(posedge mclk);
    perst_hold <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    cmp({27'h0, clk_pm_en, pci_clock_out}, 32'hf);
    $display("test straps done");
    cfg(0, 0, 12'h008, 0, {8'h06, 8'h04, 8'h00, REVISION_ID});
    cfg(1, 1, 12'h040, 32'h1234abcd, 0);
    cfg(0, 0, 12'h040, 0, 32'h1234abcd);
    cfg(0, 1, 12'h098, 32'h3, 0);
    cmp({30'h0, legacy_en, subdec_en}, 32'h3);
    cfg(0, 0, 12'h008, 0, {8'h06, 8'h04, 8'h01, REVISION_ID});
    cfg(0, 1, 12'h0b4, 32'hffffffff, 0);
    cfg(0, 0, 12'h0b4, 0, 0);
    cfg(0, 0, 12'h0b0, 0, 0);
    cfg(1, 1, 12'h104, 32'h5a5a5a5a, 0);
    cfg(1, 0, 12'h104, 0, 0);
    $display("test config done");
    cfg(0, 1, 12'h018, 32'h00050200, 0);
    cfg(0, 1, 12'h020, 32'h00200010, 0);
    cfg(0, 1, 12'h01c, 32'h0, 0);
    dn(0, 1, 8'h02, 1);
    dn(0, 1, 8'h05, 1);
    dn(0, 1, 8'h06, 0);
    dn(0, 1, 8'h01, 0);
    dn(0, 0, 8'h00, 1);
    dn(1, 0, 8'h00, 1);
    up(0, 32'h00150000, 0, 0);
    up(0, 32'h00500000, 1, 1);
    up(1, 32'h00005000, 1, 1);
    up(1, 32'h00000010, 0, 0);
    cfg(0, 1, 12'h098, 32'h0, 0);
    up(0, 32'h00500000, 1, 0);
    dn(0, 0, 8'h00, 0);
    dn(0, 1, 8'h03, 1);
    dn(0, 1, 8'h09, 0);
    $display("test decode done");
    test_done();
  end
endmodule
`default_nettype wire
